//--- verilog/nvac_cfg.svh
// constants for the nonvolatile access controller
`ifndef NVAC_CFG_SVH
`define NVAC_CFG_SVH
`define NVAC_DEPTH        64
`define NVAC_AW           6
`define NVAC_CLK_KHZ      25000
`define NVAC_T_ATOMIC_US  3400
`define NVAC_T_SPLIT_US   1800
`define NVAC_RD_STALL     3'h4
`define NVAC_PG_STALL     3'h2
`define NVAC_MPE_CYC      3'h4
`define NVAC_BIT_MODE_HI  5
`define NVAC_BIT_MODE_LO  4
`define NVAC_BIT_RIE      3
`define NVAC_BIT_MPE      2
`define NVAC_BIT_PE       1
`define NVAC_BIT_RE       0
`define NVAC_MODE_RST     2'h0
`define NVAC_ERASED       8'hff
`endif

//--- verilog/nvac_pkg.sv
// types for the nonvolatile access controller
package nvac_pkg;
  typedef enum logic [1:0] {
    NVAC_ATOMIC = 2'b00,
    NVAC_ERASE  = 2'b01,
    NVAC_WRITE  = 2'b10,
    NVAC_RSVD   = 2'b11
  } nvac_mode_t;
  typedef enum logic [1:0] {
    NVAC_IDLE  = 2'b00,
    NVAC_BUSY  = 2'b01
  } nvac_state_t;
endpackage

//--- verilog/nvac_ctrl.sv
// register interface and timing for the 64-byte data store
// Summary of operation
// - 64 bytes addressed 0 to 63 by six low address bits
// - address bits 7..6 read zero; address undefined after reset
// - data register supplies write byte and receives read byte
// - read stalls the processor four cycles
// - starting programming stalls the processor two cycles
// - control layout: mode 5..4, rie 3, mpe 2, pe 1, re 0
// - mode 00 atomic 3.4 ms, 01 erase, 10 write 1.8 ms, 11 reserved
// - mode writes ignored while program strobe is set
// - reset clears mode unless programming is in progress
// - ready interrupt level when enabled, global enable set, idle
// - program strobe acts only within four cycles of master enable
// - master enable clears itself four cycles after being written
// - device times programming; software polls the strobe
// - program strobe stays set until operation time has elapsed
// - read strobe fetches byte at once into data register
// - during programming reads refused and address frozen
// - reset does not abort programming in progress
`timescale 1ns/10ps
`include "nvac_cfg.svh"
module nvac_ctrl
  import nvac_pkg::*;
#(
  parameter int T_ATOMIC_CYC = `NVAC_T_ATOMIC_US * (`NVAC_CLK_KHZ / 1000),
  parameter int T_SPLIT_CYC  = `NVAC_T_SPLIT_US * (`NVAC_CLK_KHZ / 1000)
) (
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_global_irq_en,
  input  wire logic       i_addr_we,
  input  wire logic       i_data_we,
  input  wire logic       i_ctrl_we,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_nv_address,
  output logic      [7:0] o_nv_data,
  output logic      [7:0] o_nv_control,
  output logic            o_cpu_stall,
  output logic            o_ready_irq
);
  // timer wide enough for the longer of the two durations
  localparam int T_MAX_CYC = (T_ATOMIC_CYC > T_SPLIT_CYC) ?
    T_ATOMIC_CYC : T_SPLIT_CYC;
  localparam int TMR_W     = $clog2(T_MAX_CYC + 1);
  logic [7:0]  mem_q [`NVAC_DEPTH];
  logic [`NVAC_AW-1:0] addr_q;
  logic [7:0]  data_q;
  logic [1:0]  mode_q;
  logic        rie_q;
  logic        mpe_q;
  logic        pe_q;
  logic [2:0]  mpe_cnt_q;
  logic [2:0]  stall_q;
  logic [TMR_W-1:0] tmr_q;
  nvac_state_t state_q;

  wire busy     = (state_q == NVAC_BUSY);
  wire pe_req   = i_ctrl_we & i_wdata[`NVAC_BIT_PE];
  wire re_req   = i_ctrl_we & i_wdata[`NVAC_BIT_RE];
  wire mpe_set  = i_ctrl_we & i_wdata[`NVAC_BIT_MPE];
  wire start_pg = pe_req & mpe_q & ~pe_q & i_resetn;
  wire start_op = start_pg & (mode_q != NVAC_RSVD);
  wire do_read  = re_req & ~busy & i_resetn;
  wire tmr_done = busy & (tmr_q == '0);
  wire [TMR_W-1:0] tmr_load = (mode_q == NVAC_ATOMIC) ?
    TMR_W'(T_ATOMIC_CYC - 1) : TMR_W'(T_SPLIT_CYC - 1);

  assign o_nv_address = {2'h0, addr_q};
  assign o_nv_data    = data_q;
  assign o_nv_control = {2'h0, mode_q, rie_q, mpe_q, pe_q, 1'b0};
  assign o_cpu_stall  = (stall_q != 3'h0);
  assign o_ready_irq  = rie_q & i_global_irq_en & ~pe_q;

  // address and data; address frozen while programming
  always_ff @(posedge i_clk) begin
    if (i_addr_we && !busy) begin
      addr_q <= i_wdata[`NVAC_AW-1:0];
    end
    if (do_read) begin
      data_q <= mem_q[addr_q];
    end else if (i_data_we) begin
      data_q <= i_wdata;
    end
  end

  // storage update at start; timing held by the strobe
  always_ff @(posedge i_clk) begin
    if (start_op) begin
      unique case (mode_q)
        NVAC_ATOMIC: mem_q[addr_q] <= data_q;
        NVAC_ERASE:  mem_q[addr_q] <= `NVAC_ERASED;
        NVAC_WRITE:  mem_q[addr_q] <= mem_q[addr_q] & data_q;
        default:     mem_q[addr_q] <= mem_q[addr_q];
      endcase
    end
  end

  // programming sequencer, not touched by reset
  always_ff @(posedge i_clk) begin
    if (start_op) begin
      state_q <= NVAC_BUSY;
      pe_q    <= 1'b1;
      tmr_q   <= tmr_load;
    end else if (tmr_done) begin
      state_q <= NVAC_IDLE;
      pe_q    <= 1'b0;
    end else if (busy) begin
      tmr_q   <= tmr_q - TMR_W'(1);
    end else begin
      state_q <= NVAC_IDLE;
      pe_q    <= 1'b0;
      tmr_q   <= '0;
    end
  end

  // mode field
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      if (!pe_q) begin
        mode_q <= `NVAC_MODE_RST;
      end
    end else if (i_ctrl_we && !pe_q) begin
      mode_q <= i_wdata[`NVAC_BIT_MODE_HI:`NVAC_BIT_MODE_LO];
    end
  end

  // master enable window, interrupt enable, stall counter
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      rie_q     <= 1'b0;
      mpe_q     <= 1'b0;
      mpe_cnt_q <= 3'h0;
      stall_q   <= 3'h0;
    end else begin
      if (i_ctrl_we) begin
        rie_q <= i_wdata[`NVAC_BIT_RIE];
      end
      if (mpe_set && !mpe_q) begin
        mpe_q     <= 1'b1;
        mpe_cnt_q <= `NVAC_MPE_CYC - 3'h1;
      end else if (mpe_q && mpe_cnt_q == 3'h0) begin
        mpe_q     <= 1'b0;
      end else if (mpe_q) begin
        mpe_cnt_q <= mpe_cnt_q - 3'h1;
      end
      if (do_read) begin
        stall_q <= `NVAC_RD_STALL;
      end else if (start_pg) begin
        stall_q <= `NVAC_PG_STALL;
      end else if (stall_q != 3'h0) begin
        stall_q <= stall_q - 3'h1;
      end
    end
  end

  stall_read_a: assert property (@(posedge i_clk)
    disable iff (!i_resetn)
    do_read |=> o_cpu_stall [*4] ##1 !o_cpu_stall)
    else $error("read stall not four cycles");
  stall_prog_a: assert property (@(posedge i_clk)
    disable iff (!i_resetn)
    start_pg && !do_read |=> o_cpu_stall [*2] ##1 !o_cpu_stall)
    else $error("program stall not two cycles");
  mpe_clear_a: assert property (@(posedge i_clk)
    disable iff (!i_resetn)
    mpe_set && !mpe_q |=> mpe_q [*4] ##1 !mpe_q)
    else $error("master enable not cleared after four");
  mode_hold_a: assert property (@(posedge i_clk)
    disable iff (!i_resetn)
    pe_q |=> $stable(mode_q))
    else $error("mode changed while programming");
  mode_reset_a: assert property (@(posedge i_clk)
    !i_resetn && !pe_q
    |=> mode_q == `NVAC_MODE_RST)
    else $error("mode not cleared by reset");
  addr_hold_a: assert property (@(posedge i_clk)
    busy
    |=> $stable(addr_q))
    else $error("address changed while busy");
  addr_write_a: assert property (@(posedge i_clk)
    i_addr_we && !busy
    |=> addr_q == $past(i_wdata[`NVAC_AW-1:0]))
    else $error("address not loaded");
  no_start_a: assert property (@(posedge i_clk)
    disable iff (!i_resetn)
    pe_req && !mpe_q && !pe_q |=> !pe_q)
    else $error("strobe took effect without enable");
  irq_level_a: assert property (@(posedge i_clk)
    disable iff (!i_resetn)
    o_ready_irq == (rie_q && i_global_irq_en && !busy))
    else $error("ready interrupt wrong");
  rsvd_mode_a: assert property (@(posedge i_clk)
    disable iff (!i_resetn)
    start_pg && mode_q == NVAC_RSVD |=> !pe_q)
    else $error("reserved mode started operation");
  read_data_a: assert property (@(posedge i_clk)
    disable iff (!i_resetn)
    do_read |=> data_q == mem_q[$past(addr_q)])
    else $error("read data mismatch");
  read_refuse_a: assert property (@(posedge i_clk)
    disable iff (!i_resetn)
    re_req && busy && !i_data_we |=> $stable(data_q))
    else $error("read taken while busy");
  data_write_a: assert property (@(posedge i_clk)
    i_data_we && !do_read
    |=> data_q == $past(i_wdata))
    else $error("data register not loaded");
  ctrl_top_a: assert property (@(posedge i_clk)
    o_nv_control[7:6] == 2'h0
    && o_nv_address[7:6] == 2'h0)
    else $error("reserved bits not zero");
  prog_load_a: assert property (@(posedge i_clk)
    start_op
    |=> busy && tmr_q == $past(tmr_load))
    else $error("operation timer not loaded");
  prog_hold_a: assert property (@(posedge i_clk)
    busy && !tmr_done
    |=> busy && pe_q)
    else $error("programming ended early");
  prog_end_a: assert property (@(posedge i_clk)
    tmr_done
    |=> !busy && !pe_q)
    else $error("strobe not cleared at end");
  erase_mem_a: assert property (@(posedge i_clk)
    start_op && mode_q == NVAC_ERASE
    |=> mem_q[$past(addr_q)] == `NVAC_ERASED)
    else $error("erased byte not all ones");
  atomic_mem_a: assert property (@(posedge i_clk)
    start_op && mode_q == NVAC_ATOMIC
    |=> mem_q[$past(addr_q)] == $past(data_q))
    else $error("atomic byte not stored");

  read_c:   cover property (@(posedge i_clk) do_read);
  atomic_c: cover property (@(posedge i_clk)
    start_op && mode_q == NVAC_ATOMIC);
  split_c:  cover property (@(posedge i_clk)
    start_op && mode_q != NVAC_ATOMIC);
  done_c:   cover property (@(posedge i_clk) tmr_done);
  refuse_c: cover property (@(posedge i_clk) re_req && busy);
endmodule // nvac_ctrl

//--- tb/nvac_cpu_model.sv
// processor core model driving the register write strobes
`timescale 1ns/10ps
module nvac_cpu_model (
  input  wire logic       i_clk,
  input  wire logic       i_cpu_stall,
  output logic            o_addr_we,
  output logic            o_data_we,
  output logic            o_ctrl_we,
  output logic      [7:0] o_wdata
);
  int stalls = 0;
  initial {o_addr_we, o_data_we, o_ctrl_we, o_wdata} = 11'h000;
  // one write, at least one idle edge, then hold off while stalled
  task automatic wr(input logic [1:0] sel, input logic [7:0] val);
    {o_ctrl_we, o_data_we, o_addr_we} = 3'h1 << sel;
    o_wdata = val;
    @(posedge i_clk);
    #1;
    {o_ctrl_we, o_data_we, o_addr_we} = 3'h0;
    o_wdata = ~val;
    stalls = 0;
    do begin
      if (i_cpu_stall) begin
        stalls++;
      end
      @(posedge i_clk);
      #1;
    end while (i_cpu_stall && stalls < 9);
  endtask
endmodule // nvac_cpu_model

//--- tb/tb_nvac_ctrl.sv
// register level test of the data store controller
`timescale 1ns/10ps
module tb_nvac_ctrl;
  import nvac_pkg::*;
  logic       clk = 0, resetn = 0, gie = 1, aw, dw, cw, st, irq;
  logic [7:0] wd, na, nd, nc;
  int         errors = 0, comparisons = 0, n;
  nvac_ctrl #(.T_ATOMIC_CYC(20), .T_SPLIT_CYC(10)) uut (.i_clk(clk),
    .i_resetn(resetn), .i_global_irq_en(gie), .i_addr_we(aw),
    .i_data_we(dw), .i_ctrl_we(cw), .i_wdata(wd), .o_nv_address(na),
    .o_nv_data(nd), .o_nv_control(nc), .o_cpu_stall(st),
    .o_ready_irq(irq));
  nvac_cpu_model cpu (.i_clk(clk), .i_cpu_stall(st), .o_addr_we(aw),
    .o_data_we(dw), .o_ctrl_we(cw), .o_wdata(wd));
  initial forever #20 clk = ~clk;
  // a stall that outlasts the model's bound ends the run
  always @(posedge clk) begin
    if (cpu.stalls >= 9) begin
      errors++;
      $display("wrong value at %0t: stall never ended", $time);
      summarize();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // address, data, unlock, then strobe within the window
  task automatic prog(input logic [1:0] m, input logic [7:0] a, d);
    cpu.wr(2'h2, {2'h0, m, 4'h0});
    cpu.wr(2'h0, a);
    cpu.wr(2'h1, d);
    cpu.wr(2'h2, {2'h0, m, 4'hc});
    cpu.wr(2'h2, {2'h0, m, 4'ha});
  endtask
  // cycles until the strobe drops, bounded
  task automatic wait_done(input int exp);
    n = 0;
    while (nc[1] !== 1'b0 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 200) begin
      errors++;
      $display("wrong value at %0t: strobe never cleared", $time);
      summarize();
    end else begin
      chk(8'(n), 8'(exp));
    end
  endtask
  task automatic rd(input logic [7:0] exp);
    cpu.wr(2'h2, 8'h09);
    chk(nd, exp);
    chk(8'(cpu.stalls), 8'h04);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    #1 resetn = 1;
    cpu.wr(2'h0, 8'hc5);
    chk(na, 8'h05);
    prog(2'h0, 8'h07, 8'ha5);
    chk(8'(cpu.stalls), 8'h02);
    chk(nc & 8'hfb, 8'h0a);
    chk(8'(irq), 8'h00);
    cpu.wr(2'h0, 8'h09);
    chk(na, 8'h07);
    wait_done(16);
    chk(8'(irq), 8'h01);
    gie = 0;
    @(posedge clk);
    #1 chk(8'(irq), 8'h00);
    gie = 1;
    rd(8'ha5);
    $display("atomic program and read done");
    prog(2'h1, 8'h07, 8'h00);
    resetn = 0;
    @(posedge clk);
    #1 resetn = 1;
    chk(nc & 8'h32, 8'h12);
    cpu.wr(2'h2, 8'h01);
    chk(nd, 8'h00);
    chk(8'(cpu.stalls), 8'h00);
    wait_done(5);
    rd(8'hff);
    prog(2'h2, 8'h07, 8'h3c);
    cpu.wr(2'h2, 8'h08);
    chk(nc & 8'h30, 8'h20);
    wait_done(6);
    rd(8'h3c);
    $display("erase and write done");
    cpu.wr(2'h2, 8'h04);
    chk(nc & 8'h04, 8'h04);
    repeat (2) @(posedge clk);
    #1 chk(nc & 8'h04, 8'h04);
    @(posedge clk);
    #1 chk(nc & 8'h04, 8'h00);
    cpu.wr(2'h2, 8'h02);
    chk(nc & 8'h02, 8'h00);
    prog(2'h3, 8'h07, 8'h00);
    chk(nc & 8'h02, 8'h00);
    rd(8'h3c);
    $display("unlock and reserved mode done");
    summarize();
  end
endmodule // tb_nvac_ctrl
